/* common/bci_consts.svh */
// offsets, field positions and reset values of the backup control block
`ifndef BCI_CONSTS_SVH
`define BCI_CONSTS_SVH
`define BCI_OFF_IER 10'h000
`define BCI_OFF_IDR 10'h004
`define BCI_OFF_IMR 10'h008
`define BCI_OFF_ISR 10'h00c
`define BCI_OFF_ICR 10'h010
`define BCI_OFF_PCS 10'h014
`define BCI_OFF_KEY 10'h018
`define BCI_OFF_CHIP_SPECIFIC_CONFIG 10'h01c
`define BCI_OFF_XTAL 10'h020
`define BCI_OFF_RCCR 10'h024
`define BCI_OFF_RCTUNE 10'h028
`define BCI_OFF_IOBODCTL 10'h02c
`define BCI_OFF_IOBODLVL 10'h030
`define BCI_OFF_IOBODSMP 10'h034
`define BCI_OFF_COBODCTL 10'h038
`define BCI_OFF_COBODLVL 10'h03c
`define BCI_OFF_COBODSMP 10'h040
`define BCI_OFF_REGCFG 10'h044
`define BCI_OFF_RC1M 10'h058
`define BCI_OFF_REFCTL 10'h060
`define BCI_OFF_REFST 10'h064
`define BCI_OFF_RET0 10'h078
`define BCI_OFF_RETEND 10'h088
`define BCI_OFF_REV_RET 10'h3e4
`define BCI_OFF_REV_REF 10'h3e8
`define BCI_OFF_REV_REG 10'h3ec
`define BCI_OFF_REV_BOD 10'h3f0
`define BCI_OFF_REV_RC 10'h3f4
`define BCI_OFF_REV_XTAL 10'h3f8
`define BCI_OFF_REV_MOD 10'h3fc
`define BCI_BIT_AE 31
`define BCI_BIT_LPREF 12
`define BCI_BIT_RC1M 11
`define BCI_BIT_REG 10
`define BCI_BIT_SW 9
`define BCI_BIT_COSYNC 8
`define BCI_BIT_IOSYNC 7
`define BCI_BIT_CODET 6
`define BCI_BIT_IODET 5
`define BCI_BIT_SAT 4
`define BCI_BIT_REFE 3
`define BCI_BIT_LOCK 2
`define BCI_BIT_RDY 1
`define BCI_BIT_XTAL 0
`define BCI_EVT_MASK 32'h8000_17ff
`define BCI_STAT_MASK 32'h0000_1fff
`define BCI_ZERO 32'h0000_0000
`define BCI_XTAL_RST 32'h0000_0004
`define BCI_RC1M_RST 32'h0000_0f00
`define BCI_KEY_VAL 8'haa
`define BCI_KEY_MSB 31
`define BCI_KEY_LSB 24
`define BCI_KEY_AMSB 9
`define BCI_REFCTL_LPAUTO 0
`define BCI_REFST_ON 0
`define BCI_REFST_LPSEL 1
`define BCI_CFG_NUM 13
`define BCI_CFG_MISS 4'hf
`define BCI_CFG_TUNE 4'h3
`define BCI_CFG_IOSMP 4'h6
`define BCI_CFG_COSMP 4'h9
`define BCI_RET_NUM 4
`endif

/* common/bci_pkg.sv */
// types shared by the backup control block
`default_nettype none
package bci_pkg;
  typedef logic [31:0] bci_word_t;
  typedef enum {lock_idle, lock_armed} bci_lock_t;
endpackage : bci_pkg
`default_nettype wire

/* rtl/bci_backup_irq.sv */
// backup control: event flags, interrupt, unlock, config and retained words
// Operation
// R1: four 32-bit retained words, read and write, consecutive word offsets.
// R2: retained words keep contents through the deepest power-save state.
// R3: reference on from startup, buffers and low-power swap automatic; the code swaps only after software sets LPAUTO in REFCTL (reset 0).
// R4: protected write without correct unlock raises access error at bit 31.
// R5: listed status bits set their event flag on a 0-to-1 rise.
// R6: event bit positions fixed at 31, 12, 10 down to 0.
// R7: trim-saturated flag reads one while fine trim is saturated.
// R8: reference-error flag reads one while calibration reference stopped.
// R9: lock flag reads one once oscillator is locked to reference.
// R10: trim not ready means reads invalid and writes uncommitted.
// R11: pending event feeds interrupt only when its mask bit is set.
// R12: masked pending events ORed into one request, held until cleared.
// R13: one written to enable-set sets the mask bit; zero no effect.
// R14: one written to enable-clear clears the mask bit; zero no effect.
// R15: pending bit stays set until a one is written to pending-clear.
// R16: pending-clear one clears the bit, zero has no effect.
// R17: pending bit set on its event regardless of the mask.
// R18: write-only registers and unused bits read zero, ignore writes.
// R19: set beats a same-cycle software clear of a pending bit.
`timescale 1ns/1ns
`default_nettype none
`include "bci_consts.svh"
module bci_backup_irq #(
  parameter int P_ADDR_W = 10,
  // factory calibration dependent resets
  parameter logic [31:0] P_CALIB_RESET = 32'h0000_0000,
  // arbitrary value, revision registers only
  parameter logic [31:0] P_REVISION = 32'h0000_0100
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [P_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_lowpower_reference_ready,
  input wire logic i_rc_1m_ready,
  input wire logic i_regulator_good,
  input wire logic i_switching_stopped,
  input wire logic i_core_brownout_sync_ready,
  input wire logic i_io_brownout_sync_ready,
  input wire logic i_core_brownout_detected,
  input wire logic i_io_brownout_detected,
  input wire logic i_rc_trim_saturated,
  input wire logic i_rc_reference_error,
  input wire logic i_rc_reference_locked,
  input wire logic i_rc_trim_ready,
  input wire logic i_crystal_ready,
  input wire logic i_retention_mode,
  output logic o_irq,
  output logic o_reference_on,
  output logic o_lowpower_reference_select,
  output logic [31:0] o_rc_tuning
);

  // config word index, miss when not a config offset
  function automatic logic [3:0] cfg_idx(input logic [9:0] a);
    case (a)
      `BCI_OFF_CHIP_SPECIFIC_CONFIG: cfg_idx = 4'h0;
      `BCI_OFF_XTAL: cfg_idx = 4'h1;
      `BCI_OFF_RCCR: cfg_idx = 4'h2;
      `BCI_OFF_RCTUNE: cfg_idx = 4'h3;
      `BCI_OFF_IOBODCTL: cfg_idx = 4'h4;
      `BCI_OFF_IOBODLVL: cfg_idx = 4'h5;
      `BCI_OFF_IOBODSMP: cfg_idx = 4'h6;
      `BCI_OFF_COBODCTL: cfg_idx = 4'h7;
      `BCI_OFF_COBODLVL: cfg_idx = 4'h8;
      `BCI_OFF_COBODSMP: cfg_idx = 4'h9;
      `BCI_OFF_REGCFG: cfg_idx = 4'ha;
      `BCI_OFF_RC1M: cfg_idx = 4'hb;
      `BCI_OFF_REFCTL: cfg_idx = 4'hc;
      default: cfg_idx = `BCI_CFG_MISS;
    endcase
  endfunction : cfg_idx

  function automatic logic [31:0] cfg_rst(input logic [3:0] i);
    case (i)
      4'h1: cfg_rst = `BCI_XTAL_RST;
      4'h4, 4'h5, 4'h7, 4'h8, 4'ha: cfg_rst = P_CALIB_RESET;
      4'hb: cfg_rst = `BCI_RC1M_RST;
      default: cfg_rst = `BCI_ZERO;
    endcase
  endfunction : cfg_rst

  // bus decode
  wire [9:0] addr = 10'(i_paddr);
  wire setup = i_psel & ~i_penable;
  wire wr_en = i_psel & i_penable & i_pwrite;
  wire wr_ier = wr_en & (addr == `BCI_OFF_IER);
  wire wr_idr = wr_en & (addr == `BCI_OFF_IDR);
  wire wr_icr = wr_en & (addr == `BCI_OFF_ICR);
  wire wr_key = wr_en & (addr == `BCI_OFF_KEY);
  wire [3:0] cidx = cfg_idx(addr);
  wire cfg_hit = (cidx != `BCI_CFG_MISS);
  wire ret_hit = (addr >= `BCI_OFF_RET0) & (addr < `BCI_OFF_RETEND);
  wire [9:0] ret_off = addr - `BCI_OFF_RET0;
  wire [1:0] ret_sel = ret_off[3:2];
  wire aligned = (addr[1:0] == 2'b00);

  // live status and edge detection
  logic [31:0] status_live;
  logic [31:0] status_q;
  logic [31:0] mask_q;
  logic [31:0] pending_q;
  logic [31:0] pending_d;
  always_comb begin
    status_live = `BCI_ZERO;
    status_live[`BCI_BIT_LPREF] = i_lowpower_reference_ready;
    status_live[`BCI_BIT_RC1M] = i_rc_1m_ready;
    status_live[`BCI_BIT_REG] = i_regulator_good;
    status_live[`BCI_BIT_SW] = i_switching_stopped;
    status_live[`BCI_BIT_COSYNC] = i_core_brownout_sync_ready;
    status_live[`BCI_BIT_IOSYNC] = i_io_brownout_sync_ready;
    status_live[`BCI_BIT_CODET] = i_core_brownout_detected;
    status_live[`BCI_BIT_IODET] = i_io_brownout_detected;
    status_live[`BCI_BIT_SAT] = i_rc_trim_saturated; // R7
    status_live[`BCI_BIT_REFE] = i_rc_reference_error; // R8
    status_live[`BCI_BIT_LOCK] = i_rc_reference_locked; // R9
    status_live[`BCI_BIT_RDY] = i_rc_trim_ready;
    status_live[`BCI_BIT_XTAL] = i_crystal_ready;
  end

  // no event bit for the 1 MHz ready flag
  wire [31:0] rise = status_live & ~status_q & `BCI_EVT_MASK; // R5 R6

  // unlock sequence
  bci_pkg::bci_lock_t lock_q;
  bci_pkg::bci_lock_t lock_d;
  logic [9:0] key_addr_q;
  wire key_ok = (i_pwdata[`BCI_KEY_MSB:`BCI_KEY_LSB] == `BCI_KEY_VAL);
  wire unlocked = (lock_q == bci_pkg::lock_armed) & (key_addr_q == addr);
  wire cfg_wr = wr_en & cfg_hit & aligned;
  wire acc_err = cfg_wr & ~unlocked; // R4

  always_comb begin
    case (lock_q)
      bci_pkg::lock_idle:
        lock_d = (wr_key & key_ok) ? bci_pkg::lock_armed : bci_pkg::lock_idle;
      bci_pkg::lock_armed: begin
        // any other write spends the key, so a stray write cannot reuse it
        if (wr_key & key_ok) begin
          lock_d = bci_pkg::lock_armed;
        end else if (wr_en) begin
          lock_d = bci_pkg::lock_idle;
        end else begin
          lock_d = bci_pkg::lock_armed;
        end
      end
      default: lock_d = bci_pkg::lock_idle;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lock_q <= bci_pkg::lock_idle;
      key_addr_q <= 10'h000;
    end else begin
      lock_q <= lock_d;
      if (wr_key & key_ok) begin
        key_addr_q <= i_pwdata[`BCI_KEY_AMSB:0];
      end
    end
  end

  // event flags, mask and request
  wire [31:0] set_bits = rise | (acc_err ? 32'h8000_0000 : `BCI_ZERO); // R17
  wire [31:0] clr_bits = wr_icr ? (i_pwdata & `BCI_EVT_MASK) : `BCI_ZERO; // R16
  // set wins over clear so a same-cycle event is kept
  assign pending_d = (pending_q & ~clr_bits) | set_bits; // R15 R19
  wire [31:0] en_set = wr_ier ? (i_pwdata & `BCI_EVT_MASK) : `BCI_ZERO; // R13
  wire [31:0] en_clr = wr_idr ? (i_pwdata & `BCI_EVT_MASK) : `BCI_ZERO; // R14

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_q <= `BCI_ZERO;
      pending_q <= `BCI_ZERO;
      mask_q <= `BCI_ZERO;
    end else begin
      status_q <= status_live;
      pending_q <= pending_d;
      mask_q <= (mask_q | en_set) & ~en_clr;
    end
  end

  assign o_irq = |(pending_q & mask_q); // R11 R12

  // config words
  logic [31:0] cfg_q [`BCI_CFG_NUM];
  wire smp_io_ok = (cidx != `BCI_CFG_IOSMP) | i_io_brownout_sync_ready;
  wire smp_co_ok = (cidx != `BCI_CFG_COSMP) | i_core_brownout_sync_ready;
  wire tune_ok = (cidx != `BCI_CFG_TUNE) | i_rc_trim_ready; // R10
  wire cfg_we = cfg_wr & unlocked & smp_io_ok & smp_co_ok & tune_ok;

  genvar g;
  generate
    for (g = 0; g < `BCI_CFG_NUM; g = g + 1) begin : g_cfg
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cfg_q[g] <= cfg_rst(4'(g));
        end else if (cfg_we & (cidx == 4'(g))) begin
          cfg_q[g] <= i_pwdata;
        end
      end
    end
  endgenerate

  // committed tuning held until the trim logic reports ready
  logic [31:0] tune_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tune_q <= `BCI_ZERO;
    end else if (i_rc_trim_ready) begin
      tune_q <= cfg_q[`BCI_CFG_TUNE]; // R10
    end
  end
  assign o_rc_tuning = tune_q;

  // retained words, cleared only by the backup domain reset
  logic [31:0] ret_q [`BCI_RET_NUM];
  wire ret_we = wr_en & ret_hit & aligned;
  generate
    for (g = 0; g < `BCI_RET_NUM; g = g + 1) begin : g_ret
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          ret_q[g] <= `BCI_ZERO;
        end else if (ret_we & (ret_sel == 2'(g))) begin
          ret_q[g] <= i_pwdata; // R1 R2
        end
      end
    end
  endgenerate

  // reference control, reference on with no software action, low-power swap only once software sets LPAUTO in REFCTL
  logic ref_on_q;
  logic lpsel_q;
  wire lp_auto = cfg_q[4'hc][`BCI_REFCTL_LPAUTO];
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_on_q <= 1'b0;
      lpsel_q <= 1'b0;
    end else begin
      ref_on_q <= 1'b1; // R3
      // swap only once the low-power reference is stable
      lpsel_q <= lp_auto & i_retention_mode & i_lowpower_reference_ready; // R3
    end
  end
  assign o_reference_on = ref_on_q;
  assign o_lowpower_reference_select = lpsel_q;

  // read path, sampled in the setup cycle
  logic [31:0] rdata_d;
  logic err_d;
  logic [31:0] prdata_q;
  logic pslverr_q;
  wire [31:0] refst = {30'h0000_0000, lpsel_q, ref_on_q};
  wire tune_rd_bad = (cidx == `BCI_CFG_TUNE) & ~i_rc_trim_ready;

  always_comb begin
    rdata_d = `BCI_ZERO;
    err_d = 1'b0;
    case (addr)
      `BCI_OFF_IER, `BCI_OFF_IDR, `BCI_OFF_ICR, `BCI_OFF_KEY:
        rdata_d = `BCI_ZERO; // R18
      `BCI_OFF_IMR: rdata_d = mask_q;
      `BCI_OFF_ISR: rdata_d = pending_q;
      `BCI_OFF_PCS: rdata_d = status_q & `BCI_STAT_MASK;
      `BCI_OFF_REFST: rdata_d = refst;
      `BCI_OFF_REV_RET, `BCI_OFF_REV_REF, `BCI_OFF_REV_REG,
      `BCI_OFF_REV_BOD, `BCI_OFF_REV_RC, `BCI_OFF_REV_XTAL,
      `BCI_OFF_REV_MOD: rdata_d = P_REVISION;
      default: begin
        if (cfg_hit) begin
          rdata_d = tune_rd_bad ? `BCI_ZERO : cfg_q[cidx]; // R10
        end else if (ret_hit & aligned) begin
          rdata_d = ret_q[ret_sel]; // R1
        end else begin
          err_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata_q <= `BCI_ZERO;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= i_pwrite ? `BCI_ZERO : rdata_d;
      pslverr_q <= err_d;
    end
  end

  // zero wait states: every access completes in its first access cycle
  assign o_pready = 1'b1;
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q & i_psel & i_penable;

endmodule : bci_backup_irq
`default_nettype wire

/* testbench/bci_backup_irq_asserts.sv */
// port-level checker for the backup control block
`timescale 1ns/1ns
`default_nettype none
module bci_backup_irq_asserts #(
  parameter int P_ADDR_W = 10
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [P_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic o_irq,
  input wire logic o_reference_on,
  input wire logic o_lowpower_reference_select,
  input wire logic [31:0] o_rc_tuning,
  input wire logic i_crystal_ready,
  input wire logic i_retention_mode,
  input wire logic i_rc_trim_ready
);
  logic [31:0] mask_q;
  wire logic wr_acc = i_psel & i_penable & i_pwrite;
  wire logic rd_acc = i_psel & i_penable & ~i_pwrite;
  // mirror of the mask, only bits that own an event are kept
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) mask_q <= 32'h0000_0000;
    else if (wr_acc && i_paddr == 10'h000) mask_q <= mask_q | (i_pwdata & 32'h8000_17ff);
    else if (wr_acc && i_paddr == 10'h004) mask_q <= mask_q & ~i_pwdata;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_irq_kept;
    o_irq && !(wr_acc && (i_paddr == 10'h010 || i_paddr == 10'h004));
  endsequence
  sequence s_xtal_rise;
    $rose(i_crystal_ready) && mask_q[0] && !(wr_acc && i_paddr == 10'h004);
  endsequence
  chk_irq_held: assert property (s_irq_kept |=> o_irq)
    else $error("interrupt dropped without a clear write");
  chk_irq_masked: assert property (o_irq |-> mask_q != 32'h0000_0000)
    else $error("interrupt with empty mask");
  chk_event_raise: assert property (s_xtal_rise |=> o_irq)
    else $error("unmasked rise gave no interrupt");
  chk_mask_read: assert property (rd_acc && i_paddr == 10'h008 |-> o_prdata == mask_q)
    else $error("mask read differs");
  chk_wo_zero: assert property (rd_acc && i_paddr inside {10'h000, 10'h004, 10'h010, 10'h018}
    |-> o_prdata == 32'h0000_0000)
    else $error("write-only read not zero");
  chk_ref_on: assert property ($past(i_rst_n) |-> o_reference_on)
    else $error("reference not on after reset");
  chk_lpsel_cause: assert property (o_lowpower_reference_select |-> $past(i_retention_mode))
    else $error("low-power select outside retention");
  chk_tune_hold: assert property (!i_rc_trim_ready |=> $stable(o_rc_tuning))
    else $error("tuning moved while not ready");
  chk_err_access: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("error outside access phase");
  chk_err_unmapped: assert property (rd_acc && i_paddr == 10'h100 |-> o_pslverr)
    else $error("unmapped read gave no error");
endmodule : bci_backup_irq_asserts
bind bci_backup_irq bci_backup_irq_asserts #(.P_ADDR_W(P_ADDR_W)) u_chk (.i_clk, .i_rst_n,
  .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pslverr, .o_irq,
  .o_reference_on, .o_lowpower_reference_select, .o_rc_tuning, .i_crystal_ready,
  .i_retention_mode, .i_rc_trim_ready);
`default_nettype wire

/* testbench/test_bci_backup_irq.sv */
// self-checking bench for the backup control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module test_bci_backup_irq;
  logic i_clk = 0, i_rst_n = 0, psel = 0, pen = 0, pwr = 0, ret = 0;
  logic rdy, err, irq, refon, lps;
  logic [9:0] padr = 0;
  logic [12:0] st = 0;
  bci_pkg::bci_word_t pwd = 0, prd, tun;
  int num_errors = 0, total_checks = 0;
  initial forever #2 i_clk = ~i_clk;
  bci_backup_irq DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
    .o_pslverr(err), .i_lowpower_reference_ready(st[12]), .i_rc_1m_ready(st[11]),
    .i_regulator_good(st[10]), .i_switching_stopped(st[9]), .i_core_brownout_sync_ready(st[8]),
    .i_io_brownout_sync_ready(st[7]), .i_core_brownout_detected(st[6]),
    .i_io_brownout_detected(st[5]), .i_rc_trim_saturated(st[4]), .i_rc_reference_error(st[3]),
    .i_rc_reference_locked(st[2]), .i_rc_trim_ready(st[1]), .i_crystal_ready(st[0]),
    .i_retention_mode(ret), .o_irq(irq), .o_reference_on(refon),
    .o_lowpower_reference_select(lps), .o_rc_tuning(tun));
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [9:0] a, input bci_pkg::bci_word_t d,
    output bci_pkg::bci_word_t r, output logic e);
    int n;
    @(posedge i_clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; padr <= a; pwd <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    n = 0;
    do begin @(posedge i_clk); n++; end while (rdy !== 1'b1 && n < 50);
    if (n >= 50) begin num_errors++; summarize(); end
    r = prd; e = err;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] a, input bci_pkg::bci_word_t d);
    bci_pkg::bci_word_t r;
    logic e;
    apb(1'b1, a, d, r, e);
    @(negedge i_clk);
  endtask : wr
  task automatic rd(input logic [9:0] a, output bci_pkg::bci_word_t r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    @(negedge i_clk);
  endtask : rd
  task automatic t_reset;
    bci_pkg::bci_word_t r;
    rd(10'h008, r); `CHK("mask", 32'h0000_0000, r);
    rd(10'h00c, r); `CHK("pending", 32'h0000_0000, r);
    rd(10'h020, r); `CHK("crystal ctl", 32'h0000_0004, r);
    rd(10'h058, r); `CHK("rc1m cfg", 32'h0000_0f00, r);
    rd(10'h078, r); `CHK("retained", 32'h0000_0000, r);
    rd(10'h000, r); `CHK("wo read", 32'h0000_0000, r);
    `CHK("ref on", 1'b1, refon);
    $display("reset test done");
  endtask : t_reset
  task automatic t_events;
    bci_pkg::bci_word_t r, x;
    x = 32'h0000_0000;
    for (int b = 0; b < 13; b++) begin
      @(posedge i_clk);
      st[b] <= 1'b1;
      if (b != 11) x[b] = 1'b1;
      rd(10'h00c, r); `CHK("pending", x, r);
      `CHK("irq masked", 1'b0, irq);
    end
    rd(10'h014, r); `CHK("status", 32'h0000_1fff, r);
    wr(10'h000, 32'h0000_0000); rd(10'h008, r); `CHK("mask", 32'h0000_0000, r);
    wr(10'h000, 32'hffff_ffff); rd(10'h008, r); `CHK("mask", 32'h8000_17ff, r);
    `CHK("irq", 1'b1, irq);
    wr(10'h004, 32'h0000_17fe); rd(10'h008, r); `CHK("mask", 32'h8000_0001, r);
    wr(10'h010, 32'h0000_17fe); `CHK("irq", 1'b1, irq);
    @(posedge i_clk);
    st <= 13'h0000;
    rd(10'h00c, r); `CHK("pending", 32'h0000_0001, r);
    wr(10'h010, 32'h0000_0001); `CHK("irq", 1'b0, irq);
    @(posedge i_clk);
    st[0] <= 1'b1;
    repeat (2) @(negedge i_clk);
    `CHK("irq rise", 1'b1, irq);
    wr(10'h010, 32'h0000_0001); `CHK("irq cleared", 1'b0, irq);
    // clear lands on the same edge that samples the rise
    fork
      wr(10'h010, 32'h0000_0400);
      begin
        repeat (2) @(posedge i_clk);
        st[10] <= 1'b1;
      end
    join
    rd(10'h00c, r); `CHK("set beats clear", 32'h0000_0400, r);
    wr(10'h010, 32'h0000_0400);
    rd(10'h00c, r); `CHK("pending", 32'h0000_0000, r);
    $display("event test done");
  endtask : t_events
  task automatic t_access;
    bci_pkg::bci_word_t r;
    wr(10'h01c, 32'h0000_0001); rd(10'h00c, r); `CHK("pending", 32'h8000_0000, r);
    rd(10'h01c, r); `CHK("cfg kept", 32'h0000_0000, r);
    wr(10'h010, 32'h8000_0000); wr(10'h000, 32'h8000_0000);
    wr(10'h018, 32'haa00_001c); wr(10'h01c, 32'h0000_0001);
    rd(10'h00c, r); `CHK("pending", 32'h0000_0000, r);
    wr(10'h01c, 32'h0000_0001); `CHK("irq", 1'b1, irq);
    wr(10'h010, 32'h8000_0000); `CHK("irq", 1'b0, irq);
    $display("access test done");
  endtask : t_access
  task automatic t_retain;
    bci_pkg::bci_word_t r;
    logic e;
    for (int i = 0; i < 4; i++) wr(10'(10'h078 + 4 * i), 32'(32'h1111_1111 * (i + 1)));
    @(posedge i_clk);
    ret <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(10'(10'h078 + 4 * i), r); `CHK("retained", 32'(32'h1111_1111 * (i + 1)), r);
    end
    wr(10'h018, 32'haa00_0060); wr(10'h060, 32'h0000_0001);
    @(posedge i_clk);
    st[12] <= 1'b1;
    rd(10'h064, r); `CHK("ref state", 32'h0000_0003, r);
    `CHK("lp select", 1'b1, lps);
    @(posedge i_clk);
    ret <= 1'b0;
    repeat (2) @(negedge i_clk);
    `CHK("lp select", 1'b0, lps);
    wr(10'h018, 32'haa00_0028); wr(10'h028, 32'h0000_0055);
    rd(10'h028, r); `CHK("tune read", 32'h0000_0000, r);
    `CHK("tune out", 32'h0000_0000, tun);
    apb(1'b0, 10'h100, 32'h0000_0000, r, e); `CHK("unmapped err", 1'b1, e);
    $display("retain test done");
  endtask : t_retain
  task automatic t_guard;
    bci_pkg::bci_word_t r;
    wr(10'h018, 32'haa00_0034); wr(10'h034, 32'h0000_0005);
    rd(10'h034, r); `CHK("io sampling", 32'h0000_0000, r);
    wr(10'h018, 32'haa00_0040); wr(10'h040, 32'h0000_0006);
    rd(10'h040, r); `CHK("core sampling", 32'h0000_0000, r);
    @(posedge i_clk);
    st <= st | 13'h0182;
    wr(10'h018, 32'haa00_0034); wr(10'h034, 32'h0000_0005);
    rd(10'h034, r); `CHK("io sampling", 32'h0000_0005, r);
    wr(10'h018, 32'haa00_0040); wr(10'h040, 32'h0000_0006);
    rd(10'h040, r); `CHK("core sampling", 32'h0000_0006, r);
    wr(10'h018, 32'haa00_0028); wr(10'h028, 32'h0000_0055);
    rd(10'h028, r); `CHK("tune read", 32'h0000_0055, r);
    `CHK("tune out", 32'h0000_0055, tun);
    rd(10'h00c, r); `CHK("pending", 32'h0000_1182, r);
    $display("guard test done");
  endtask : t_guard
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_events();
    t_access();
    t_retain();
    t_guard();
    summarize();
  end
endmodule : test_bci_backup_irq
`undef CHK
`default_nettype wire
